// ===== src/cec_tx_defs.vh
// Constants for the CEC transmit control and receive waveform check block.
// Assumes inclusion by cec_tx_wave.v; definitions only.
`ifndef CEC_TX_DEFS_VH
`define CEC_TX_DEFS_VH
`define OFS_TX_ENABLE 8'h00
`define OFS_TX_DATA 8'h04
`define OFS_TX_TIMING 8'h08
`define OFS_WAVE_CFG 8'h0c
`define OFS_WAVE_STAT 8'h10
`define TX_DATA_MASK 32'h000001ff
`define TX_TIMING_MASK 32'h00777f1f
`define WAVE_CFG_MASK 32'h00017777
`define RST_TX_DATA 9'h000
`define RST_TX_TIMING 32'h00000000
`define RST_WAVE_CFG 17'h00000
`define EARLY_ONE_BASE 8'd13
`define AMB_START_BASE 8'd26
`define AMB_END_BASE 8'd43
`define LATE_ZERO_BASE 8'd56
`define START_RISE_BASE 8'd121
`define START_PERIOD_BASE 8'd147
`define ONE_RISE_BASE 8'd20
`define ZERO_RISE_BASE 8'd49
`define DATA_PERIOD_BASE 8'd79
`define FS_DIV_DEFAULT 16'd7629
`endif

// ===== src/cec_tx_wave.v
// CEC transmitter control with receive waveform checking and an AXI4-Lite slave.
// Assumes fs is derived here from core_clk by a divider; cecIn is an async pin.
//
// Notes on behaviour
// - Flag error when received rise comes after 56 plus 0..7 fs periods.
// - No rise between bit start and late-zero limit makes the bit erroneous.
// - Waveform errors are raised only while the check enable bit is 1.
// - Rise inside the ambiguous window between one and zero limits is an error.
// - Ambiguous window starts at 26 plus 0..7 fs periods.
// - Ambiguous window ends at 43 minus 0..7 fs periods.
// - Rise earlier than 13 minus 0..7 fs periods is an error.
// - A rise between bit start and early-one limit marks the bit erroneous.
// - Busy flag sets at start bit, clears on completion or interrupt.
// - Writes to the busy flag are ignored.
// - Writing 1 to transmit enable starts sending; 0 disables.
// - Transmit enable clears on completion or error interrupt.
// - End-of-message bit comes from data register bit 8.
// - Data byte comes from bits 7..0, sent MSB first.
// - Start bit rises at 121 and ends at 147 fs, each minus 0..7.
// - Data bit rises at 20 for one, 49 for zero, each minus 0..3.
// - Data bit lasts 79 minus 0..15 fs periods.
// - Wait bus free for code plus one bit periods before starting.
`timescale 1ns/1ns
`include "cec_tx_defs.vh"
module cec_tx_wave #(
    parameter [15:0] FS_DIV = `FS_DIV_DEFAULT
) (
    input wire core_clk,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire receive_enable,
    input wire cecIn,
    output reg cecOutEn,
    output reg txDoneIrq,
    output reg txErrIrq,
    output reg waveErrIrq
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_FREE = 5'h02;
    localparam [4:0] ST_START = 5'h04;
    localparam [4:0] ST_DATA = 5'h08;
    localparam [4:0] ST_ACK = 5'h10;

    reg [8:0] txData_r;
    reg [31:0] txTiming_r;
    reg [16:0] waveCfg_r;
    reg waveErr_r;
    reg transmit_enable_r;
    reg transmit_in_progress_r;
    reg [4:0] state_r;
    reg [15:0] fsDiv_r;
    reg fsTick;
    reg [7:0] txCnt_r;
    reg [3:0] bitIdx_r;
    reg [3:0] freeCnt_r;
    reg [7:0] rxCnt_r;
    reg rxActive_r;
    reg rxSeenRise_r;
    reg cecSync1_r;
    reg cecSync2_r;
    reg cecPrev_r;
    reg awHeld_r;
    reg wHeld_r;
    reg [7:0] awAddr_r;
    reg [31:0] wData_r;
    reg [3:0] wStrb_r;

    // Byte-lane merge for a register write
    function [31:0] lane_merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            lane_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    lane_merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    wire [2:0] startRiseTrim = txTiming_r[22:20];
    wire [2:0] startPeriodTrim = txTiming_r[18:16];
    wire [1:0] dataRiseTrim = txTiming_r[13:12];
    wire [3:0] dataPeriodTrim = txTiming_r[11:8];
    wire [3:0] busFreeTime = txTiming_r[3:0];
    wire [2:0] earlyOneTrim = waveCfg_r[2:0];
    wire [2:0] ambStartTrim = waveCfg_r[6:4];
    wire [2:0] ambEndTrim = waveCfg_r[10:8];
    wire [2:0] lateZeroTrim = waveCfg_r[14:12];
    wire waveCheckEn = waveCfg_r[16];

    wire [7:0] startRise = `START_RISE_BASE - {5'h00, startRiseTrim};
    wire [7:0] startPeriod = `START_PERIOD_BASE - {5'h00, startPeriodTrim};
    wire [7:0] dataPeriod = `DATA_PERIOD_BASE - {4'h0, dataPeriodTrim};
    wire curBit = (bitIdx_r < 4'd8) ? txData_r[3'd7 - bitIdx_r[2:0]]
        : txData_r[8];
    wire [7:0] dataRise = (curBit ? `ONE_RISE_BASE : `ZERO_RISE_BASE)
        - {6'h00, dataRiseTrim};
    wire [7:0] earlyOne = `EARLY_ONE_BASE - {5'h00, earlyOneTrim};
    wire [7:0] ambStart = `AMB_START_BASE + {5'h00, ambStartTrim};
    wire [7:0] ambEnd = `AMB_END_BASE - {5'h00, ambEndTrim};
    wire [7:0] lateZero = `LATE_ZERO_BASE + {5'h00, lateZeroTrim};

    wire rxFall = cecPrev_r & ~cecSync2_r;
    wire rxRise = ~cecPrev_r & cecSync2_r;
    wire [31:0] txDataMerged = lane_merge({23'h0, txData_r}, wData_r, wStrb_r) & `TX_DATA_MASK;
    wire [31:0] waveCfgMerged = lane_merge({15'h0, waveCfg_r}, wData_r, wStrb_r) & `WAVE_CFG_MASK;

    // fs tick divider
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fsDiv_r <= 16'h0000;
            fsTick <= 1'b0;
        end else begin
            fsTick <= (fsDiv_r == FS_DIV - 16'h0001);
            fsDiv_r <= (fsDiv_r == FS_DIV - 16'h0001) ? 16'h0000 : fsDiv_r + 16'h0001;
        end
    end

    // Pin synchroniser; only the second stage feeds logic
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cecSync1_r <= 1'b1;
            cecSync2_r <= 1'b1;
            cecPrev_r <= 1'b1;
        end else begin
            cecSync1_r <= cecIn;
            cecSync2_r <= cecSync1_r;
            cecPrev_r <= cecSync2_r;
        end
    end

    // Receive waveform check; own transmission is not checked
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxActive_r <= 1'b0;
            rxCnt_r <= 8'h00;
            rxSeenRise_r <= 1'b0;
            waveErrIrq <= 1'b0;
        end else begin
            waveErrIrq <= 1'b0;
            if (!receive_enable || !waveCheckEn || transmit_in_progress_r) begin
                rxActive_r <= 1'b0;
            end else if (rxFall) begin
                rxActive_r <= 1'b1;
                rxCnt_r <= 8'h00;
                rxSeenRise_r <= 1'b0;
            end else if (rxActive_r) begin
                if (fsTick && rxCnt_r != 8'hff) begin
                    rxCnt_r <= rxCnt_r + 8'h01;
                end
                if (rxRise && !rxSeenRise_r) begin
                    rxSeenRise_r <= 1'b1;
                    if (rxCnt_r < earlyOne) begin
                        waveErrIrq <= 1'b1;
                    end else if (rxCnt_r > ambStart && rxCnt_r < ambEnd) begin
                        waveErrIrq <= 1'b1;
                    end
                end else if (!rxSeenRise_r && fsTick && rxCnt_r == lateZero) begin
                    waveErrIrq <= 1'b1;
                    rxActive_r <= 1'b0;
                end
            end
        end
    end

    // Transmitter; an ack-slot low from the other side past the rise raises txErrIrq as a lost line
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            transmit_in_progress_r <= 1'b0;
            txCnt_r <= 8'h00;
            bitIdx_r <= 4'h0;
            freeCnt_r <= 4'h0;
            cecOutEn <= 1'b1;
            txDoneIrq <= 1'b0;
            txErrIrq <= 1'b0;
        end else begin
            txDoneIrq <= 1'b0;
            txErrIrq <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    cecOutEn <= 1'b1;
                    txCnt_r <= 8'h00;
                    freeCnt_r <= 4'h0;
                    if (transmit_enable_r) begin
                        state_r <= ST_FREE;
                    end
                end
                ST_FREE: begin
                    if (!transmit_enable_r) begin
                        state_r <= ST_IDLE;
                    end else if (!cecSync2_r) begin
                        txCnt_r <= 8'h00; // Bus busy: restart the free wait
                        freeCnt_r <= 4'h0;
                    end else if (fsTick) begin
                        if (txCnt_r == dataPeriod - 8'h01) begin
                            txCnt_r <= 8'h00;
                            if (freeCnt_r == busFreeTime) begin
                                state_r <= ST_START;
                                transmit_in_progress_r <= 1'b1;
                                cecOutEn <= 1'b0;
                            end else begin
                                freeCnt_r <= freeCnt_r + 4'h1;
                            end
                        end else begin
                            txCnt_r <= txCnt_r + 8'h01;
                        end
                    end
                end
                ST_START, ST_DATA: begin
                    if (!transmit_enable_r) begin
                        state_r <= ST_IDLE;
                        transmit_in_progress_r <= 1'b0;
                        cecOutEn <= 1'b1;
                    end else if (cecOutEn && !cecSync2_r
                            && txCnt_r > (state_r == ST_START ? startRise : dataRise)) begin
                        // Wait one fs tick past our own release so the synchroniser settles
                        // Line held low by another party: lost arbitration
                        txErrIrq <= 1'b1;
                        transmit_in_progress_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end else if (fsTick) begin
                        txCnt_r <= txCnt_r + 8'h01;
                        if (txCnt_r + 8'h01 == (state_r == ST_START ? startRise : dataRise)) begin
                            cecOutEn <= 1'b1;
                        end
                        if (txCnt_r + 8'h01 == (state_r == ST_START ? startPeriod : dataPeriod)) begin
                            txCnt_r <= 8'h00;
                            if (state_r == ST_DATA && bitIdx_r == 4'd9) begin
                                state_r <= ST_ACK;
                            end else begin
                                cecOutEn <= 1'b0;
                                bitIdx_r <= (state_r == ST_START) ? 4'h0 : bitIdx_r + 4'h1;
                                state_r <= ST_DATA;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    txDoneIrq <= 1'b1;
                    transmit_in_progress_r <= 1'b0;
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // AXI4-Lite slave, single outstanding write and read
    wire wrFire = awHeld_r && wHeld_r && !s_axi_bvalid;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h00000000;
            wStrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h00000000;
            txData_r <= `RST_TX_DATA;
            txTiming_r <= `RST_TX_TIMING;
            waveCfg_r <= `RST_WAVE_CFG;
            transmit_enable_r <= 1'b0;
            waveErr_r <= 1'b0;
        end else begin
            s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (txDoneIrq || txErrIrq) begin
                transmit_enable_r <= 1'b0;
            end
            if (waveErrIrq) begin
                waveErr_r <= 1'b1;
            end
            if (wrFire) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                if (awAddr_r[7:2] == `OFS_TX_ENABLE >> 2) begin
                    if (wStrb_r[0]) begin
                        transmit_enable_r <= wData_r[0];
                    end
                end else if (awAddr_r[7:2] == `OFS_TX_DATA >> 2) begin
                    txData_r <= txDataMerged[8:0];
                end else if (awAddr_r[7:2] == `OFS_TX_TIMING >> 2) begin
                    txTiming_r <= lane_merge(txTiming_r, wData_r, wStrb_r) & `TX_TIMING_MASK;
                end else if (awAddr_r[7:2] == `OFS_WAVE_CFG >> 2) begin
                    waveCfg_r <= waveCfgMerged[16:0];
                end else if (awAddr_r[7:2] == `OFS_WAVE_STAT >> 2) begin
                    // Write one to clear; a new error in the same cycle wins
                    if (wStrb_r[0] && wData_r[0] && !waveErrIrq) begin
                        waveErr_r <= 1'b0;
                    end
                end else begin
                    s_axi_bresp <= 2'b10;
                end
            end
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                if (s_axi_araddr[7:2] == `OFS_TX_ENABLE >> 2) begin
                    s_axi_rdata <= {30'h0, transmit_in_progress_r, 1'b0};
                end else if (s_axi_araddr[7:2] == `OFS_TX_DATA >> 2) begin
                    s_axi_rdata <= {23'h0, txData_r};
                end else if (s_axi_araddr[7:2] == `OFS_TX_TIMING >> 2) begin
                    s_axi_rdata <= txTiming_r;
                end else if (s_axi_araddr[7:2] == `OFS_WAVE_CFG >> 2) begin
                    s_axi_rdata <= {15'h0, waveCfg_r};
                end else if (s_axi_araddr[7:2] == `OFS_WAVE_STAT >> 2) begin
                    s_axi_rdata <= {31'h0, waveErr_r};
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'b10;
                end
            end
        end
    end
endmodule

// ===== tb/cec_line_partner.sv
// Line partner: another CEC node on the shared, pulled-up wire.
// Assumes the device pulls the wire while cecOutEn is low; times in core_clk cycles.
`timescale 1ns/1ns
module cec_line_partner #(
    parameter int FS_DIV = 4
) (
    input logic core_clk,
    input logic cecOutEn,
    output logic cecIn
);
    logic rel = 1'h1;
    logic prevLvl = 1'h1;
    int lowCnt = 0;
    int perCnt = 0;
    int lowQ[$];
    int perQ[$];
    // Wired-AND: any party pulling wins, a released wire floats high
    assign cecIn = cecOutEn & rel;
    always @(posedge core_clk) begin
        if (prevLvl && !cecIn) begin
            perQ.push_back(perCnt);
            perCnt = 1;
            lowCnt = 1;
        end else begin
            perCnt = perCnt + 1;
            lowCnt = lowCnt + (cecIn ? 0 : 1);
        end
        if (!prevLvl && cecIn) begin
            lowQ.push_back(lowCnt);
        end
        prevLvl = cecIn;
    end
    task automatic sendBit(input int lowFs, input int perFs);
        rel <= 1'h0;
        repeat (lowFs * FS_DIV) @(posedge core_clk);
        rel <= 1'h1;
        repeat ((perFs - lowFs) * FS_DIV) @(posedge core_clk);
    endtask
    // Only a scenario that wants a lost line calls this
    task automatic holdLow(input int n);
        rel <= 1'h0;
        repeat (n) @(posedge core_clk);
        rel <= 1'h1;
    endtask
endmodule

// ===== tb/cec_tx_wave_checker.sv
// Checker: bus, line and interrupt relations at the cec_tx_wave ports.
// Assumes it is bound onto cec_tx_wave and sees only that module's ports.
`timescale 1ns/1ns
module cec_tx_wave_checker #(
    parameter int FS_DIV = 4
) (
    input logic core_clk,
    input logic rst_n,
    input logic s_axi_awready,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic receive_enable,
    input logic cecOutEn,
    input logic txDoneIrq,
    input logic txErrIrq,
    input logic waveErrIrq
);
    // Shortest low is a fully trimmed one, longest an untrimmed start bit
    localparam int LO_MIN = 17 * FS_DIV - 2;
    localparam int LO_MAX = 121 * FS_DIV + 2;
    int lowCnt_r;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lowCnt_r <= 0;
        end else begin
            lowCnt_r <= cecOutEn ? 0 : lowCnt_r + 1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready held too long");
    a_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
        else $error("wready held too long");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_low_span: assert property ($rose(cecOutEn) |-> lowCnt_r >= LO_MIN && lowCnt_r <= LO_MAX)
        else $error("driven low of wrong length");
    a_done_release: assert property (txDoneIrq |-> cecOutEn [*8])
        else $error("line pulled right after done");
    a_err_release: assert property (txErrIrq |=> cecOutEn [*8])
        else $error("line pulled after lost line");
    a_wave_gate: assert property (!receive_enable [*3] |-> !waveErrIrq)
        else $error("waveform error while not receiving");
    a_irq_apart: assert property (!(txDoneIrq && txErrIrq))
        else $error("done and error together");
    c_done: cover property (txDoneIrq);
    c_lost: cover property (txErrIrq);
    c_wave: cover property (waveErrIrq);
endmodule

// ===== tb/cec_tx_wave_tb.sv
// Bench for cec_tx_wave: registers, transmit timing, lost line, waveform checks.
// Assumes the line partner and the checker; fs is 4 core clocks here.
`timescale 1ns/1ns
bind cec_tx_wave cec_tx_wave_checker #(.FS_DIV(FS_DIV)) chkr (.*);
module cec_tx_wave_tb;
    localparam int FS = 4;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic receive_enable = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rd;
    logic [1:0] rr, wr;
    logic cecIn, cecOutEn, txDoneIrq, txErrIrq, waveErrIrq;
    int errTotal = 0;
    int numChecks = 0;
    int doneCnt = 0;
    int txErrCnt = 0;
    int waveCnt = 0;
    always #2 core_clk = ~core_clk;
    cec_tx_wave #(.FS_DIV(16'h4)) dut (.*);
    cec_line_partner #(.FS_DIV(FS)) peer (.core_clk(core_clk), .cecOutEn(cecOutEn), .cecIn(cecIn));
    always @(posedge core_clk) begin
        if (txDoneIrq === 1'h1) doneCnt <= doneCnt + 1;
        if (txErrIrq === 1'h1) txErrCnt <= txErrCnt + 1;
        if (waveErrIrq === 1'h1) waveCnt <= waveCnt + 1;
    end
    task automatic fail(input string m);
        errTotal++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        numChecks++;
        if (got !== exp) fail(m);
    endtask
    // One cycle of slack: the line is sampled on core_clk, not on fs ticks
    task automatic near(input int got, input int exp, input string m);
        numChecks++;
        if (got < exp - 1 || got > exp + 1) fail(m);
    endtask
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && n < 100);
        wr = s_axi_bresp;
        s_axi_bready <= 1'h0;
        if (n >= 100) fail("write hung");
        @(posedge core_clk);
    endtask
    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1 && n < 100);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (n >= 100) fail("read hung");
        @(posedge core_clk);
    endtask
    task automatic waitLine(input logic lvl, input int lim);
        int n;
        n = 0;
        while (cecOutEn !== lvl && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= lim) fail("line wait expired");
    endtask
    task automatic waitCnt(ref int c, input int base, input int lim);
        int n;
        n = 0;
        while (c == base && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= lim) fail("event wait expired");
    endtask
    task automatic testRegs();
        axiRead(8'h00, rd, rr);
        check(rd, 32'h0, "enable reset");
        check({30'h0, rr}, 32'h0, "read resp");
        axiRead(8'h08, rd, rr);
        check(rd, 32'h0, "timing reset");
        axiWrite(8'h00, 32'hfffffffe);
        axiRead(8'h00, rd, rr);
        check(rd, 32'h0, "busy write kept");
        axiWrite(8'h04, 32'hffffffff);
        check({30'h0, wr}, 32'h0, "write resp");
        axiRead(8'h04, rd, rr);
        check(rd, 32'h000001ff, "data mask");
        axiWrite(8'h08, 32'hffffffff);
        axiRead(8'h08, rd, rr);
        check(rd, 32'h00777f1f, "timing mask");
        axiRead(8'h40, rd, rr);
        check({30'h0, rr}, 32'h2, "unmapped resp");
        axiWrite(8'h40, 32'h0);
        check({30'h0, wr}, 32'h2, "unmapped write resp");
    endtask
    task automatic testTransmit();
        logic [8:0] seq;
        int base;
        seq = {8'ha5, 1'h1};
        axiWrite(8'h08, 32'h00352910);
        axiWrite(8'h04, 32'h000001a5);
        peer.lowQ.delete();
        peer.perQ.delete();
        base = doneCnt;
        axiWrite(8'h00, 32'h00000001);
        waitLine(1'h0, 3000);
        axiRead(8'h00, rd, rr);
        check(rd, 32'h2, "busy in frame");
        waitCnt(doneCnt, base, 6000);
        axiRead(8'h00, rd, rr);
        check(rd, 32'h0, "busy after done");
        near(peer.lowQ[0], 118 * FS, "start low");
        near(peer.perQ[1], 142 * FS, "start period");
        for (int i = 0; i < 9; i++) begin
            near(peer.lowQ[i + 1], (seq[8 - i] ? 18 : 47) * FS, "bit low");
        end
        for (int i = 2; i < 11; i++) begin
            near(peer.perQ[i], 70 * FS, "bit period");
        end
        repeat (1500) @(posedge core_clk);
        // Start, eight data bits, EOM and the driven ack slot
        check(peer.lowQ.size(), 11, "pulse count");
    endtask
    task automatic testLost();
        int base;
        base = txErrCnt;
        axiWrite(8'h00, 32'h00000001);
        waitLine(1'h0, 3000);
        waitLine(1'h1, 1000);
        repeat (20) @(posedge core_clk);
        peer.holdLow(40);
        waitCnt(txErrCnt, base, 200);
        axiRead(8'h00, rd, rr);
        check(rd, 32'h0, "busy after loss");
        peer.lowQ.delete();
        repeat (1500) @(posedge core_clk);
        check(peer.lowQ.size(), 0, "restart after loss");
    endtask
    task automatic testWave();
        int lows[8] = '{9, 13, 27, 31, 39, 44, 55, 59};
        int errs[8] = '{1, 0, 0, 1, 1, 0, 0, 1};
        int base;
        receive_enable <= 1'h0;
        axiWrite(8'h0c, 32'h00011232);
        receive_enable <= 1'h1;
        @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            base = waveCnt;
            peer.sendBit(lows[i], 79);
            repeat (4) @(posedge core_clk);
            check(waveCnt - base, errs[i], "wave verdict");
        end
        axiRead(8'h10, rd, rr);
        check(rd, 32'h1, "sticky set");
        axiWrite(8'h10, 32'h1);
        axiRead(8'h10, rd, rr);
        check(rd, 32'h0, "sticky clear");
        receive_enable <= 1'h0;
        axiWrite(8'h0c, 32'h00001232);
        receive_enable <= 1'h1;
        @(posedge core_clk);
        base = waveCnt;
        peer.sendBit(31, 79);
        check(waveCnt - base, 0, "check disabled");
    endtask
    task automatic completeRun();
        $display("checks %0d mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #(4 * 60000);
        fail("watchdog");
        completeRun();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'h1;
        @(posedge core_clk);
        testRegs();
        testTransmit();
        testLost();
        testWave();
        completeRun();
    end
endmodule
